//--- design/ahp_port.sv
/*
 Asynchronous 16-bit host bus port: strobe capture, register access, DMA request, interrupt pin.
 Assumes all host pins are asynchronous to clk_sys_in and the core answers a register
 read in the same cycle that reg_rd_out is high.
*/
`timescale 1ns/1ps
`include "ahp_defines.svh"

module ahp_port (
    // Clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Host pins
    input wire logic cs_n_in,
    input wire logic [`AHP_WADDR_W-1:0] addr_in,
    input wire logic buffer_window_select_in,
    input wire logic rd_strobe_n_in,
    input wire logic wr_strobe_n_in,
    input wire logic [1:0] byte_lane_enable_n_in,
    input wire logic [`AHP_DATA_W-1:0] data_in,
    output logic [`AHP_DATA_W-1:0] data_out,
    output logic data_oe_out,
    output logic int_n_out,
    output logic int_oe_out,
    output logic dma_request_line_out,
    // Core register access
    output logic reg_rd_out,
    output logic reg_wr_out,
    output logic [7:0] reg_addr_out,
    output logic [`AHP_DATA_W-1:0] reg_wdata_out,
    output logic [1:0] reg_be_out,
    input wire logic [`AHP_DATA_W-1:0] reg_rdata_in,
    // Core configuration and status
    input wire logic irq_in,
    input wire logic int_open_drain_in,
    input wire logic dma_enable_in,
    input wire logic dma_dir_wr_in,
    input wire logic [`AHP_BURST_W-1:0] dma_burst_in,
    input wire logic [`AHP_GAP_W-1:0] dma_delay_in,
    input wire logic sd_clk_tick_in,
    input wire logic [`AHP_PEND_W-1:0] rx_pending_in,
    input wire logic [`AHP_PEND_W-1:0] tx_space_in,
    // Receive stream into the FIFO
    input wire logic rx_valid_in,
    input wire logic [`AHP_DATA_W-1:0] rx_data_in,
    output logic rx_ready_out
);
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] rd_s;
        logic [1:0] wr_s;
        logic [1:0] bws_s;
        logic [1:0][`AHP_WADDR_W-1:0] addr_s;
        logic [1:0][`AHP_DATA_W-1:0] dat_s;
        logic [1:0][1:0] be_s;
        logic rd_prev;
        logic wr_prev;
        ahp_pkg::ahp_dma_e dma;
        logic [`AHP_BURST_W-1:0] beat;
        logic [`AHP_GAP_W-1:0] gap;
        logic port1;
        logic rd_pend;
        logic [7:0] addr;
        ahp_pkg::ahp_word_t dout;
        logic wdma;
        logic [`AHP_WADDR_W-1:0] whold_addr;
        ahp_pkg::ahp_word_t wdata;
        logic [1:0] wbe;
        logic wstb;
        logic rstb;
        logic int_n;
        logic int_oe;
        logic dma_request_line;
    } ahp_state_s;

    ahp_state_s s;
    ahp_state_s next_s;

    ahp_fifo_if #(.WIDTH(`AHP_DATA_W), .DEPTH(`AHP_FIFO_DEPTH)) rxf ();

    ahp_fifo #(.WIDTH(`AHP_DATA_W), .DEPTH(`AHP_FIFO_DEPTH)) u_rx_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .f(rxf.fifo)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] byte_off(input logic [`AHP_WADDR_W-1:0] a);
        byte_off = {a, 1'b0};
    endfunction : byte_off

    function automatic logic [7:0] port_off(input logic p1);
        port_off = p1 ? `AHP_OFF_BDP1 : `AHP_OFF_BDP0;
    endfunction : port_off

    logic cs_act;
    logic rd_now;
    logic wr_now;
    logic rd_start;
    logic wr_end;
    logic dma_tgt;
    logic dma_rd;
    logic dma_acc;
    logic [`AHP_BURST_W-1:0] burst_eff;
    logic [`AHP_PEND_W:0] rx_level;
    logic level_ok;

    // ----------------------------------------
    // Strobe qualification on synchronised pins
    // ----------------------------------------
    assign cs_act = !s.cs_s[1];
    assign rd_now = cs_act && !s.rd_s[1];
    assign wr_now = cs_act && !s.wr_s[1];
    assign rd_start = rd_now && !s.rd_prev;
    // Writes commit on the trailing edge so data and lanes are settled
    assign wr_end = s.wr_prev && !wr_now;
    assign dma_tgt = dma_enable_in && s.bws_s[1];
    assign dma_rd = rd_start && dma_tgt;
    assign dma_acc = ce_in && (dma_rd || (wr_end && s.wdma));
    // A zero burst would raise a request with no data waiting; treat it as one word
    assign burst_eff = (dma_burst_in == '0) ? `AHP_BURST_W'(1) : dma_burst_in;
    assign rx_level = (`AHP_PEND_W+1)'(rxf.count) + (`AHP_PEND_W+1)'(rx_pending_in);
    assign level_ok = dma_dir_wr_in ? (tx_space_in >= `AHP_PEND_W'(burst_eff))
                                    : (rx_level >= (`AHP_PEND_W+1)'(burst_eff));

    // ----------------------------------------
    // FIFO hookup
    // ----------------------------------------
    assign rxf.wr_valid = rx_valid_in;
    assign rxf.wr_data = rx_data_in;
    assign rx_ready_out = rxf.wr_ready;
    assign rxf.rd_ready = ce_in && dma_rd;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        if (ce_in) begin
            // Two-stage synchronisers for every host pin
            next_s.cs_s = {s.cs_s[0], cs_n_in};
            next_s.rd_s = {s.rd_s[0], rd_strobe_n_in};
            next_s.wr_s = {s.wr_s[0], wr_strobe_n_in};
            next_s.bws_s = {s.bws_s[0], buffer_window_select_in};
            next_s.addr_s = {s.addr_s[0], addr_in};
            next_s.dat_s = {s.dat_s[0], data_in};
            next_s.be_s = {s.be_s[0], byte_lane_enable_n_in};
            next_s.rd_prev = rd_now;
            next_s.wr_prev = wr_now;
            next_s.rstb = 1'b0;
            next_s.wstb = 1'b0;
            next_s.rd_pend = 1'b0;

            // Read path
            if (s.rd_pend) begin
                next_s.dout = reg_rdata_in;
            end
            if (rd_start) begin
                if (dma_tgt) begin
                    next_s.addr = port_off(s.port1);
                    next_s.port1 = !s.port1;
                    next_s.dout = rxf.rd_valid ? rxf.rd_data : `AHP_DATA_RST;
                end else begin
                    next_s.addr = byte_off(s.addr_s[1]);
                    next_s.rstb = 1'b1;
                    next_s.rd_pend = 1'b1;
                end
            end

            // Write path: hold bus state while the strobe is low
            if (wr_now) begin
                next_s.wdata = s.dat_s[1];
                next_s.wbe = s.be_s[1];
                next_s.whold_addr = s.addr_s[1];
                next_s.wdma = dma_tgt;
            end
            if (wr_end && (s.wbe != 2'b11)) begin
                next_s.wstb = 1'b1;
                next_s.addr = s.wdma ? port_off(s.port1) : byte_off(s.whold_addr);
                if (s.wdma) begin
                    next_s.port1 = !s.port1;
                end
            end else if (wr_end && s.wdma) begin
                next_s.port1 = !s.port1;
            end

            // DMA request sequencing
            unique case (s.dma)
                ahp_pkg::AHP_DMA_IDLE: begin
                    next_s.beat = '0;
                    if (dma_enable_in && level_ok) begin
                        next_s.dma = ahp_pkg::AHP_DMA_ARMED;
                    end
                end
                ahp_pkg::AHP_DMA_ARMED: begin
                    if (dma_acc) begin
                        if (s.beat + `AHP_BURST_W'(1) >= burst_eff) begin
                            next_s.beat = '0;
                            next_s.gap = dma_delay_in;
                            next_s.dma = ahp_pkg::AHP_DMA_GAP;
                        end else begin
                            next_s.beat = s.beat + `AHP_BURST_W'(1);
                        end
                    end
                end
                ahp_pkg::AHP_DMA_GAP: begin
                    // Delay counted in card clock periods
                    if (sd_clk_tick_in) begin
                        if (s.gap == '0) begin
                            next_s.dma = ahp_pkg::AHP_DMA_IDLE;
                        end else begin
                            next_s.gap = s.gap - `AHP_GAP_W'(1);
                        end
                    end
                end
                default: begin
                    next_s.dma = ahp_pkg::AHP_DMA_IDLE;
                end
            endcase
            if (!dma_enable_in) begin
                next_s.dma = ahp_pkg::AHP_DMA_IDLE;
                next_s.port1 = 1'b0;
            end
            next_s.dma_request_line = (next_s.dma == ahp_pkg::AHP_DMA_ARMED);

            // Interrupt pin driver
            next_s.int_n = int_open_drain_in ? 1'b0 : !irq_in;
            next_s.int_oe = int_open_drain_in ? irq_in : 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
            s.cs_s <= 2'h3;
            s.rd_s <= 2'h3;
            s.wr_s <= 2'h3;
            s.be_s <= 4'hf;
            s.wbe <= 2'h3;
            s.int_n <= 1'b1;
            s.dma <= ahp_pkg::AHP_DMA_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign data_out = s.dout;
    // Released three clocks after the read strobe or select goes away
    assign data_oe_out = s.rd_prev;
    assign int_n_out = s.int_n;
    assign int_oe_out = s.int_oe;
    assign dma_request_line_out = s.dma_request_line;
    assign reg_rd_out = s.rstb;
    assign reg_wr_out = s.wstb;
    assign reg_addr_out = s.addr;
    assign reg_wdata_out = s.wdata;
    assign reg_be_out = ~s.wbe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence burst_done_s;
        s.dma == ahp_pkg::AHP_DMA_ARMED ##1 s.dma == ahp_pkg::AHP_DMA_GAP;
    endsequence

    sequence gap_hold_s;
        !dma_request_line_out ##1 !dma_request_line_out;
    endsequence

    a_cs_gates_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && s.cs_s[1]) |=> !reg_rd_out) else $error("Read issued without select");

    a_read_word_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && rd_start && !dma_tgt) |=> (reg_rd_out && reg_addr_out ==
        {$past(s.addr_s[1]), 1'b0})) else $error("Read address not decoded");

    a_write_low_lane: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && wr_end) |=> (reg_be_out[0] == !$past(s.wbe[0])))
        else $error("Low lane enable wrong");

    a_write_high_lane: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && wr_end && $past(s.wbe[1])) |=> !reg_be_out[1] || !reg_wr_out)
        else $error("High lane written while disabled");

    a_oe_only_reads: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !rd_now) |=> !data_oe_out) else $error("Data bus driven outside read");

    a_int_pin_mode: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && irq_in) |=> (int_oe_out && !int_n_out)) else $error("Interrupt not asserted");

    a_dma_request_line_has_data: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(dma_request_line_out) |-> $past(level_ok && dma_enable_in))
        else $error("Request raised without data");

    a_dma_request_line_gap_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        burst_done_s |-> gap_hold_s) else $error("Request not held low after burst");

    a_port_alternate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && dma_rd) |=> (reg_addr_out == ($past(s.port1) ? `AHP_OFF_BDP1 :
        `AHP_OFF_BDP0)) && (s.port1 != $past(s.port1))) else $error("Port did not alternate");

    a_offset_even: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !reg_addr_out[0]) else $error("Odd register offset");
endmodule : ahp_port

//--- include/ahp_defines.svh
/*
 Constants of the asynchronous host bus port: register offsets, widths and depths.
 Assumes it is included by bare name from the package and the design files.
*/
`ifndef AHP_DEFINES_SVH
`define AHP_DEFINES_SVH

// ----------------------------------------
// Widths and depths
// ----------------------------------------
`define AHP_DATA_W 16
`define AHP_WADDR_W 7
`define AHP_FIFO_DEPTH 8
`define AHP_BURST_W 9
`define AHP_GAP_W 7
`define AHP_PEND_W 11

// ----------------------------------------
// Offsets and reset values
// ----------------------------------------
`define AHP_OFF_BDP0 8'h20
`define AHP_OFF_BDP1 8'h22
`define AHP_DATA_RST 16'h0000

`endif

//--- include/ahp_pkg.sv
/*
 Types of the asynchronous host bus port.
 Assumes the defines header sits on the include path.
*/
`include "ahp_defines.svh"

package ahp_pkg;

    // ----------------------------------------
    // DMA request sequencing
    // ----------------------------------------
    typedef enum logic [1:0] {
        AHP_DMA_IDLE,
        AHP_DMA_ARMED,
        AHP_DMA_GAP
    } ahp_dma_e;

    typedef logic [`AHP_DATA_W-1:0] ahp_word_t;

endpackage : ahp_pkg

//--- include/ahp_fifo_if.sv
/*
 Carrier between the port and its receive FIFO: fill side, drain side, fill level.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`include "ahp_defines.svh"

interface ahp_fifo_if #(
    parameter int WIDTH = `AHP_DATA_W,
    parameter int DEPTH = `AHP_FIFO_DEPTH
);
    logic wr_valid;
    logic wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [WIDTH-1:0] rd_data;
    logic [$clog2(DEPTH):0] count;

    modport fifo (
        input wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data, count
    );
    modport user (
        output wr_valid, wr_data, rd_ready,
        input wr_ready, rd_valid, rd_data, count
    );
endinterface : ahp_fifo_if

//--- design/ahp_fifo.sv
/*
 Receive FIFO between the core's read stream and host DMA reads.
 Assumes one clock; the drain side stalls by holding rd_ready low.
*/
`timescale 1ns/1ps
`include "ahp_defines.svh"

module ahp_fifo #(
    parameter int WIDTH = `AHP_DATA_W,
    parameter int DEPTH = `AHP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Stream sides
    ahp_fifo_if.fifo f
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW:0] cnt;
    } ahp_fifo_state_s;

    ahp_fifo_state_s s;
    ahp_fifo_state_s next_s;
    logic push;
    logic pop;

    // ----------------------------------------
    // Flags: full and empty come from the count, never guessed
    // ----------------------------------------
    // Not ready while frozen, so no word is handed over and then dropped
    assign f.wr_ready = ce_in && (s.cnt != (PW+1)'(DEPTH));
    assign f.rd_valid = (s.cnt != '0);
    assign f.rd_data = s.mem[s.rptr];
    assign f.count = s.cnt;
    assign push = f.wr_valid && f.wr_ready;
    assign pop = f.rd_ready && f.rd_valid;

    always_comb begin
        next_s = s;
        if (ce_in) begin
            if (push) begin
                next_s.mem[s.wptr] = f.wr_data;
                next_s.wptr = (s.wptr == PW'(DEPTH - 1)) ? '0 : s.wptr + PW'(1);
            end
            if (pop) begin
                next_s.rptr = (s.rptr == PW'(DEPTH - 1)) ? '0 : s.rptr + PW'(1);
            end
            if (push && !pop) begin
                next_s.cnt = s.cnt + (PW+1)'(1);
            end else if (pop && !push) begin
                next_s.cnt = s.cnt - (PW+1)'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s.cnt <= (PW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule : ahp_fifo

//--- bench/ahp_host_model.sv
/*
 Host bus master model that drives the port's pins, DMA window reads included.
 Assumes one clock; every pin but the idle data bus changes 1 ns after a rising edge.
*/
`timescale 1ns/1ps

module ahp_host_model (
    // Clock
    input wire logic clk_sys_in,
    // Bus as driven by the device
    input wire logic [15:0] data_dev_in,
    input wire logic data_oe_in,
    // Pins to the device
    output logic cs_n_out,
    output logic [6:0] addr_out,
    output logic buffer_window_select_out,
    output logic rd_strobe_n_out,
    output logic wr_strobe_n_out,
    output logic [1:0] byte_lane_enable_n_out,
    output logic [15:0] data_out
);
    logic [15:0] wdat;
    logic [15:0] idle = 16'h5a5a;
    logic own = 1'b0;

    // Undriven bus toggles so a stale value can never pass for read data
    always @(posedge clk_sys_in) begin
        if (!own) idle <= ~idle;
    end
    assign data_out = own ? wdat : (data_oe_in ? data_dev_in : idle);

    initial begin
        cs_n_out = 1'b1;
        addr_out = 7'h00;
        buffer_window_select_out = 1'b0;
        rd_strobe_n_out = 1'b1;
        wr_strobe_n_out = 1'b1;
        byte_lane_enable_n_out = 2'h3;
    end

    // ----------------------------------------
    // One bus cycle, strobe low and high 6 cycles each
    // ----------------------------------------
    task automatic access(input logic rd, input logic cs_n, input logic [6:0] a,
                          input logic bw, input logic [1:0] ln, input logic [15:0] d);
        @(posedge clk_sys_in) #1;
        cs_n_out = cs_n;
        addr_out = a;
        buffer_window_select_out = bw;
        byte_lane_enable_n_out = ln;
        wdat = d;
        own = !rd;
        if (rd) rd_strobe_n_out = 1'b0;
        else wr_strobe_n_out = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #1;
        rd_strobe_n_out = 1'b1;
        wr_strobe_n_out = 1'b1;
        cs_n_out = 1'b1;
        own = 1'b0;
        buffer_window_select_out = 1'b0;
        repeat (6) @(posedge clk_sys_in);
    endtask : access
endmodule : ahp_host_model

//--- bench/async_host_bus_port_bench.sv
/*
 Self-checking bench of the host port: register cycles, lanes, interrupt pin, DMA stream.
 Assumes the host model drives the pins and this bench plays the core side.
*/
`timescale 1ns/1ps
`include "ahp_defines.svh"

module async_host_bus_port_bench;
    logic clk_sys_in, rst_in, irq, od, dma_en, tick, rx_valid, rx_ready;
    logic [15:0] rx_data, din, dout, reg_wd;
    logic [8:0] burst = 9'h004;
    logic [6:0] gap = 7'h02;
    logic cs_n, bws, rd_n, wr_n, data_oe, int_n, int_oe, dma_request_line, reg_rd, reg_wr;
    logic [6:0] addr;
    logic [1:0] lanes_n, reg_be, last_be;
    logic [7:0] reg_addr;
    logic [15:0] last_wd, exp;
    int error_cnt = 0, checked = 0, cyc = 0, rd_cnt, wr_cnt, oe_cnt, w;
    logic [15:0] q[$];

    ahp_port dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1),
        .cs_n_in(cs_n), .addr_in(addr), .buffer_window_select_in(bws),
        .rd_strobe_n_in(rd_n), .wr_strobe_n_in(wr_n), .byte_lane_enable_n_in(lanes_n),
        .data_in(din), .data_out(dout), .data_oe_out(data_oe), .int_n_out(int_n),
        .int_oe_out(int_oe), .dma_request_line_out(dma_request_line), .reg_rd_out(reg_rd),
        .reg_wr_out(reg_wr), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wd),
        .reg_be_out(reg_be), .reg_rdata_in({reg_addr, ~reg_addr}), .irq_in(irq),
        .int_open_drain_in(od), .dma_enable_in(dma_en), .dma_dir_wr_in(1'b0),
        .dma_burst_in(burst), .dma_delay_in(gap), .sd_clk_tick_in(tick),
        .rx_pending_in(11'h000), .tx_space_in(11'h000), .rx_valid_in(rx_valid),
        .rx_data_in(rx_data), .rx_ready_out(rx_ready));

    ahp_host_model host_u (.clk_sys_in(clk_sys_in), .data_dev_in(dout),
        .data_oe_in(data_oe), .cs_n_out(cs_n), .addr_out(addr),
        .buffer_window_select_out(bws), .rd_strobe_n_out(rd_n), .wr_strobe_n_out(wr_n),
        .byte_lane_enable_n_out(lanes_n), .data_out(din));

    // ----------------------------------------
    // Clock, card tick, timeout, monitor
    // ----------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        tick <= (cyc[3:0] == 4'h0);
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    // Sampled mid-cycle so registered pulses are settled
    always @(negedge clk_sys_in) begin
        if (reg_rd) rd_cnt++;
        if (data_oe) oe_cnt++;
        if (reg_wr) begin
            wr_cnt++;
            last_wd = reg_wd;
            last_be = reg_be;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic acc(input logic rd, input logic c, input logic [6:0] a, input logic bw,
                       input logic [1:0] ln, input logic [15:0] d);
        rd_cnt = 0;
        wr_cnt = 0;
        oe_cnt = 0;
        host_u.access(rd, c, a, bw, ln, d);
    endtask : acc

    task automatic push(input logic [15:0] d);
        @(posedge clk_sys_in) #1;
        rx_valid = 1'b1;
        rx_data = d;
        for (w = 0; w < 50 && !rx_ready; w++) @(posedge clk_sys_in) #1;
        @(posedge clk_sys_in) #1;
        rx_valid = 1'b0;
        q.push_back(d);
    endtask : push

    task automatic results();
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    logic [6:0] a;
    logic [15:0] d;
    initial begin
        rst_in = 1'b1;
        {irq, od, dma_en, rx_valid, rx_data} = '0;
        void'($urandom(31026));
        repeat (2) @(posedge clk_sys_in);
        #1;
        check({data_oe, int_n, int_oe, dma_request_line, rx_ready}, 16'h0009);
        rst_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            a = 7'($urandom());
            acc(1'b1, 1'b0, a, 1'b0, 2'h0, 16'h0000);
            check(16'(rd_cnt), 16'h0001);
            check({8'h00, reg_addr}, {8'h00, a, 1'b0});
            check(dout, {a, 1'b0, ~a, 1'b1});
            check({15'h0, oe_cnt != 0, data_oe}, 16'h0002);
        end
        // Every lane pattern, both-high must not reach the core
        for (int ln = 0; ln < 4; ln++) begin
            a = 7'($urandom());
            d = 16'($urandom());
            acc(1'b0, 1'b0, a, 1'b0, 2'(ln), d);
            check(16'(wr_cnt), (ln == 3) ? 16'h0000 : 16'h0001);
            check(16'(oe_cnt), 16'h0000);
            if (ln != 3) begin
                check({8'h00, reg_addr}, {8'h00, a, 1'b0});
                check({14'h0, last_be}, {14'h0, ~2'(ln)});
                check(last_wd, d);
            end
        end
        acc(1'b1, 1'b1, 7'h10, 1'b0, 2'h0, 16'h0000);
        check(16'(rd_cnt + oe_cnt), 16'h0000);
        acc(1'b0, 1'b1, 7'h10, 1'b0, 2'h0, 16'h1234);
        check(16'(rd_cnt + wr_cnt), 16'h0000);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_in) #1;
            {od, irq} = 2'(k);
            repeat (3) @(posedge clk_sys_in);
            #1;
            check({int_n, int_oe}, od ? {1'b0, irq} : {~irq, 1'b1});
        end
        @(posedge clk_sys_in) #1;
        dma_en = 1'b1;
        for (int i = 0; i < 3; i++) push(16'($urandom()));
        repeat (4) @(posedge clk_sys_in);
        #1;
        check(16'(dma_request_line), 16'h0000);
        for (int i = 0; i < 5; i++) push(16'($urandom()));
        repeat (3) @(posedge clk_sys_in);
        #1;
        check({dma_request_line, rx_ready}, 16'h0002);
        // Ten accesses: eight words, then two on the emptied buffer
        for (int n = 0; n < 10; n++) begin
            if (n == 4) begin
                check(16'(dma_request_line), 16'h0000);
                for (w = 0; w < 100 && !dma_request_line; w++) @(posedge clk_sys_in) #1;
                check({15'h0, dma_request_line && w >= 15}, 16'h0001);
            end
            exp = (q.size() != 0) ? q.pop_front() : 16'h0000;
            acc(1'b1, 1'b0, 7'($urandom()), 1'b1, 2'h0, 16'h0000);
            check(dout, exp);
            check({8'h00, reg_addr}, n[0] ? 16'h0022 : 16'h0020);
        end
        results();
    end
endmodule : async_host_bus_port_bench
